// ==== mmsp_slave_port.sv ====
// Memory-mapped slave port with variable stalling for reads; writes complete with zero waits
`timescale 1ns/1ps
module mmsp_slave_port
  import mmsp_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic chipSelect,
  input wire logic [MMSP_ADDR_W-1:0] address,
  input wire logic readStrobe,
  input wire logic writeStrobe,
  input wire logic [MMSP_LANES-1:0] byteEnable,
  input wire logic byteEnableUsed,
  input wire logic [MMSP_DATA_W-1:0] writeData,
  input wire logic [MMSP_LAT_W-1:0] readLatency,
  output logic [MMSP_DATA_W-1:0] readData,
  output logic waitRequest,
  output logic writeDone,
  output logic [MMSP_LAT_W-1:0] lastStallCount
);
  mmsp_state_t state_r;
  mmsp_state_t state_nxt;
  logic [MMSP_LAT_W-1:0] cnt_r;
  logic [MMSP_LAT_W-1:0] cnt_nxt;
  logic [MMSP_DATA_W-1:0] readData_r;
  logic [MMSP_DATA_W-1:0] readData_nxt;
  logic writeDone_r;
  logic writeDone_nxt;
  logic [MMSP_LAT_W-1:0] lastStall_r;
  logic [MMSP_LAT_W-1:0] lastStall_nxt;
  logic [MMSP_LAT_W:0] stallLen_r;
  logic [MMSP_LAT_W:0] stallLen_nxt;
  logic [MMSP_DATA_W-1:0] memRd;
  logic [MMSP_DATA_W-1:0] laneMask;

  // Select gates both the read and the write strobe
  wire selRead = chipSelect && readStrobe;
  // Level qualified write, no edge on select needed
  wire selWrite = chipSelect && writeStrobe && !readStrobe;
  // Bounded read latency
  wire [MMSP_LAT_W-1:0] latLimit =
    (readLatency > MMSP_MAX_STALL) ? MMSP_MAX_STALL : readLatency;
  wire latDone = (cnt_r >= latLimit);
  wire inIdle = (state_r == MMSP_IDLE);
  wire inStall = (state_r == MMSP_STALL);
  wire inDone = (state_r == MMSP_DONE);
  wire readStart = inIdle && selRead;
  wire readAbort = inStall && !selRead;
  wire readFinish = inStall && selRead && latDone;

  function automatic logic [MMSP_LAT_W-1:0] mmsp_inc(input logic [MMSP_LAT_W-1:0] v);
    mmsp_inc = (v == MMSP_MAX_STALL) ? v : v + 4'h1;
  endfunction

  // Saturating length count for the stall bound check
  function automatic logic [MMSP_LAT_W:0] mmsp_len_inc(input logic [MMSP_LAT_W:0] v);
    mmsp_len_inc = (&v) ? v : v + 5'h01;
  endfunction

  mmsp_lane_mask u_mask (
    .laneEn(byteEnable),
    .lanesUsed(byteEnableUsed),
    .bitMask(laneMask)
  );

  mmsp_mem u_mem (
    .sys_clk(sys_clk),
    .wrEn(selWrite),
    .wrAddr(address),
    .wrData(writeData),
    .wrMask(laneMask),
    .rdAddr(address),
    .rdData(memRd)
  );

  // Read sequencer
  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    case (state_r)
      MMSP_IDLE:
      begin
        cnt_nxt = MMSP_CNT_RST;
        if (selRead)
        begin
          state_nxt = MMSP_STALL;
        end
      end
      MMSP_STALL:
      begin
        cnt_nxt = mmsp_inc(cnt_r);
        if (!selRead)
        begin
          state_nxt = MMSP_IDLE;
        end
        else if (latDone)
        begin
          state_nxt = MMSP_DONE;
        end
      end
      MMSP_DONE:
      begin
        state_nxt = MMSP_IDLE;
      end
      default:
      begin
        state_nxt = MMSP_IDLE;
      end
    endcase
  end

  // Stall from first read cycle until data held; writes complete with zero waits
  assign waitRequest = selRead && !inDone;
  assign readData_nxt = readFinish ? memRd : readData_r;
  assign lastStall_nxt = readFinish ? cnt_r : lastStall_r;
  assign writeDone_nxt = selWrite;
  assign stallLen_nxt = waitRequest ? mmsp_len_inc(stallLen_r) : {1'b0, MMSP_CNT_RST};
  assign readData = readData_r;
  assign writeDone = writeDone_r;
  assign lastStallCount = lastStall_r;

  // One short register process per value
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_r <= MMSP_IDLE;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cnt_r <= MMSP_CNT_RST;
    end
    else
    begin
      cnt_r <= cnt_nxt;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      readData_r <= MMSP_DATA_RST;
    end
    else
    begin
      readData_r <= readData_nxt;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      lastStall_r <= MMSP_CNT_RST;
    end
    else
    begin
      lastStall_r <= lastStall_nxt;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      writeDone_r <= 1'b0;
    end
    else
    begin
      writeDone_r <= writeDone_nxt;
    end
  end

  // Helper for the stall bound check
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      stallLen_r <= {1'b0, MMSP_CNT_RST};
    end
    else
    begin
      stallLen_r <= stallLen_nxt;
    end
  end

  // Assertions
  a_stall_first_cycle: assert property (@(posedge sys_clk) disable iff (!reset_n)
    readStart |-> waitRequest)
    else $error("Read not stalled in first cycle");

  a_stall_bounded: assert property (@(posedge sys_clk) disable iff (!reset_n)
    $rose(waitRequest) && selRead |-> ##[1:20] !waitRequest)
    else $error("Stall not released in time");

  a_stall_len_limit: assert property (@(posedge sys_clk) disable iff (!reset_n)
    waitRequest |-> (stallLen_r <= ({1'b0, MMSP_MAX_STALL} + 5'h01)))
    else $error("Stall lasted beyond the clamp");

  a_data_at_release: assert property (@(posedge sys_clk) disable iff (!reset_n)
    inDone |-> (readData == u_mem.mem[address]))
    else $error("Read data not valid at stall release");

  a_data_stands: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !readFinish |=> $stable(readData))
    else $error("Read data changed without a read");

  a_read_no_hold: assert property (@(posedge sys_clk) disable iff (!reset_n)
    inDone |-> !waitRequest ##1 inIdle)
    else $error("Read extended past capture");

  a_write_no_stall: assert property (@(posedge sys_clk) disable iff (!reset_n)
    selWrite |-> !waitRequest)
    else $error("Write stalled unexpectedly");

  a_write_one_cycle: assert property (@(posedge sys_clk) disable iff (!reset_n)
    selWrite |=> writeDone)
    else $error("Write not completed in one cycle");

  a_deselect_quiet: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !chipSelect |-> (!waitRequest ##1 !writeDone))
    else $error("Port acted while deselected");

  a_abort_idle: assert property (@(posedge sys_clk) disable iff (!reset_n)
    readAbort |=> inIdle)
    else $error("Dropped read not abandoned");

  a_back_to_back: assert property (@(posedge sys_clk) disable iff (!reset_n)
    selWrite ##1 selWrite |-> writeDone ##1 writeDone)
    else $error("Back-to-back writes lost");

  a_stall_count: assert property (@(posedge sys_clk) disable iff (!reset_n)
    inStall |-> (cnt_r <= latLimit))
    else $error("Stall counter passed its limit");

  a_count_start: assert property (@(posedge sys_clk) disable iff (!reset_n)
    readStart |=> (cnt_r == MMSP_CNT_RST))
    else $error("Stall counter not cleared at read start");

  a_last_count: assert property (@(posedge sys_clk) disable iff (!reset_n)
    readFinish |=> (lastStallCount == $past(latLimit)))
    else $error("Stall length differs from latency");

  a_lane_low: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (selWrite && byteEnableUsed) |-> (laneMask[7:0] == {8{byteEnable[0]}}))
    else $error("Low lane mask wrong");

  a_lane_high: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (selWrite && byteEnableUsed) |-> (laneMask[MMSP_DATA_W-1 -: 8] == {8{byteEnable[3]}}))
    else $error("High lane mask wrong");

  a_lanes_all: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (selWrite && !byteEnableUsed) |-> (&laneMask))
    else $error("Lane enables honoured while unused");

  a_read_wins: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (chipSelect && readStrobe) |-> !selWrite)
    else $error("Write taken during a read");

  // Main scenarios
  c_read_stall: cover property (@(posedge sys_clk) disable iff (!reset_n)
    waitRequest ##1 waitRequest ##1 !waitRequest);
  c_write_burst: cover property (@(posedge sys_clk) disable iff (!reset_n)
    selWrite ##1 selWrite ##1 selWrite);
  c_partial_lane: cover property (@(posedge sys_clk) disable iff (!reset_n)
    selWrite && byteEnableUsed && byteEnable != {MMSP_LANES{1'b1}});
  c_write_after_read: cover property (@(posedge sys_clk) disable iff (!reset_n)
    inDone ##1 selWrite);
  c_long_stall: cover property (@(posedge sys_clk) disable iff (!reset_n)
    readFinish && (cnt_r > 4'h3));
endmodule

// ==== mmsp_pkg.sv ====
// Package: constants and types for the memory-mapped slave port
package mmsp_pkg;
  localparam int MMSP_ADDR_W = 6;
  localparam int MMSP_DATA_W = 32;
  localparam int MMSP_LANES = MMSP_DATA_W / 8;
  localparam int MMSP_DEPTH = 64;
  localparam int MMSP_LAT_W = 4;
  localparam logic [MMSP_LAT_W-1:0] MMSP_READ_LAT = 4'h1;
  localparam logic [MMSP_LAT_W-1:0] MMSP_MAX_STALL = 4'hf;
  localparam logic [MMSP_DATA_W-1:0] MMSP_DATA_RST = 32'h0000_0000;
  localparam logic [MMSP_LAT_W-1:0] MMSP_CNT_RST = 4'h0;
  typedef enum logic [1:0] {MMSP_IDLE, MMSP_STALL, MMSP_DONE} mmsp_state_t;
endpackage

// ==== mmsp_lane_mask.sv ====
// Byte lane mask builder
`timescale 1ns/1ps
module mmsp_lane_mask
  import mmsp_pkg::*;
(
  input wire logic [MMSP_LANES-1:0] laneEn,
  input wire logic lanesUsed,
  output logic [MMSP_DATA_W-1:0] bitMask
);
  wire [MMSP_LANES-1:0] effLanes;
  assign effLanes = lanesUsed ? laneEn : {MMSP_LANES{1'b1}};
  genvar i;
  generate
    for (i = 0; i < MMSP_LANES; i++)
    begin : g_lane
      assign bitMask[i*8 +: 8] = {8{effLanes[i]}};
    end
  endgenerate
endmodule

// ==== mmsp_mem.sv ====
// Little storage array with registered read data
`timescale 1ns/1ps
module mmsp_mem
  import mmsp_pkg::*;
(
  input wire logic sys_clk,
  input wire logic wrEn,
  input wire logic [MMSP_ADDR_W-1:0] wrAddr,
  input wire logic [MMSP_DATA_W-1:0] wrData,
  input wire logic [MMSP_DATA_W-1:0] wrMask,
  input wire logic [MMSP_ADDR_W-1:0] rdAddr,
  output logic [MMSP_DATA_W-1:0] rdData
);
  logic [MMSP_DATA_W-1:0] mem [MMSP_DEPTH];
  always_ff @(posedge sys_clk)
  begin
    if (wrEn)
    begin
      mem[wrAddr] <= (mem[wrAddr] & ~wrMask) | (wrData & wrMask);
    end
    rdData <= mem[rdAddr];
  end
endmodule

// ==== mmsp_fabric_model.sv ====
// Fabric model that starts transfers on the slave port
`timescale 1ns/1ps
module mmsp_fabric_model
  import mmsp_pkg::*;
(
  input wire logic sys_clk,
  input wire logic waitRequest,
  input wire logic [MMSP_DATA_W-1:0] readData,
  output logic chipSelect,
  output logic [MMSP_ADDR_W-1:0] address,
  output logic readStrobe,
  output logic writeStrobe,
  output logic [MMSP_LANES-1:0] byteEnable,
  output logic [MMSP_DATA_W-1:0] writeData
);
  initial
  begin
    chipSelect = 1'b0;
    address = 6'h00;
    readStrobe = 1'b0;
    writeStrobe = 1'b0;
    byteEnable = 4'h0;
    writeData = 32'h0000_0000;
  end
  // Start just after an edge, hold until waitRequest low at an edge
  task automatic xfer(input logic s, input logic rd, input logic [MMSP_ADDR_W-1:0] a,
    input logic [MMSP_LANES-1:0] be, input logic [MMSP_DATA_W-1:0] d,
    output int n, output logic [MMSP_DATA_W-1:0] q);
    n = 0;
    chipSelect = s;
    address = a;
    readStrobe = rd;
    writeStrobe = !rd;
    byteEnable = be;
    writeData = rd ? ~writeData : d;
    @(posedge sys_clk);
    while (waitRequest === 1'b1 && n < 40)
    begin
      n++;
      @(posedge sys_clk);
    end
    q = readData;
    #1;
  endtask
  // Released address and write data lines show a changed pattern, not the last value; byteEnable keeps its last value
  task automatic idle();
    chipSelect = 1'b0;
    readStrobe = 1'b0;
    writeStrobe = 1'b0;
    address = ~address;
    writeData = ~writeData;
  endtask
endmodule

// ==== mmsp_slave_port_tb.sv ====
// Testbench for the memory-mapped slave port
`timescale 1ns/1ps
module mmsp_slave_port_tb;
  import mmsp_pkg::*;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic chipSelect, readStrobe, writeStrobe, byteEnableUsed, waitRequest, writeDone;
  logic [MMSP_ADDR_W-1:0] address;
  logic [MMSP_LANES-1:0] byteEnable;
  logic [MMSP_DATA_W-1:0] writeData, readData, q;
  logic [MMSP_DATA_W-1:0] expMem [4];
  logic [MMSP_LAT_W-1:0] readLatency = 4'h0;
  logic [MMSP_LAT_W-1:0] lastStallCount;
  int badCount = 0;
  int checksDone = 0;
  int doneCount = 0;
  int n;
  always #12.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (writeDone === 1'b1) doneCount++;
  mmsp_slave_port u_dut (.sys_clk(sys_clk), .reset_n(reset_n), .chipSelect(chipSelect),
    .address(address), .readStrobe(readStrobe), .writeStrobe(writeStrobe),
    .byteEnable(byteEnable), .byteEnableUsed(byteEnableUsed), .writeData(writeData),
    .readLatency(readLatency), .readData(readData), .waitRequest(waitRequest),
    .writeDone(writeDone), .lastStallCount(lastStallCount));
  mmsp_fabric_model u_fab (.sys_clk(sys_clk), .waitRequest(waitRequest),
    .readData(readData), .chipSelect(chipSelect), .address(address),
    .readStrobe(readStrobe), .writeStrobe(writeStrobe), .byteEnable(byteEnable),
    .writeData(writeData));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checksDone++;
    if (seen !== exp)
    begin
      badCount++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic finishTest();
    if (badCount == 0 && checksDone > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    #50000;
    badCount++;
    finishTest();
  end
  initial
  begin
    byteEnableUsed = 1'b1;
    repeat (10) @(posedge sys_clk);
    #1 reset_n = 1'b1;
    @(posedge sys_clk);
    #1;
    // Back-to-back writes: full, partial lanes, lanes unused, then one with select low
    for (int i = 0; i < 4; i++)
    begin
      expMem[i] = 32'hc3c3_0000 | i;
      u_fab.xfer(1'b1, 1'b0, 6'(i), 4'hf, expMem[i], n, q);
      check(n, 0);
    end
    u_fab.xfer(1'b1, 1'b0, 6'h01, 4'h5, 32'h1122_3344, n, q);
    expMem[1] = (expMem[1] & 32'hff00_ff00) | 32'h0022_0044;
    byteEnableUsed = 1'b0;
    u_fab.xfer(1'b1, 1'b0, 6'h02, 4'h0, 32'h5566_7788, n, q);
    expMem[2] = 32'h5566_7788;
    byteEnableUsed = 1'b1;
    u_fab.xfer(1'b0, 1'b0, 6'h03, 4'hf, 32'hdead_beef, n, q);
    u_fab.idle();
    @(posedge sys_clk);
    #1;
    check(doneCount, 6);
    // Back-to-back reads with varying stall lengths, then one full write
    for (int i = 0; i < 4; i++)
    begin
      readLatency = (i == 2) ? 4'h5 : 4'(i);
      u_fab.xfer(1'b1, 1'b1, 6'(i), 4'hf, 32'h0, n, q);
      check(n, readLatency + 2);
      check(q, expMem[i]);
      check(lastStallCount, readLatency);
    end
    u_fab.xfer(1'b1, 1'b0, 6'h00, 4'hf, 32'h0f0f_0f0f, n, q);
    check(n, 0);
    u_fab.idle();
    repeat (2) @(posedge sys_clk);
    #1;
    check(doneCount, 7);
    finishTest();
  end
endmodule
